// *** ata_pio_in_command_accept.sv ***
`timescale 1ns/1ps
// Contract
// RULE1 - Commands are taken only while busy is clear; host never writes during busy.
// RULE2 - Class one command raises busy within 400 ns of the command write.
// RULE3 - Class two: busy within 400 ns, prepare buffer, data request, busy off.
// RULE4 - Host must not rely on seeing busy for class two commands.
// RULE5 - Data-in commands move one or more 512-byte blocks to the host.
// RULE6 - Host loads task parameters before writing the command code.
// RULE7 - Busy while preparing; data request and busy clear precede interrupt.
// RULE8 - Host reads status first, then exactly one block of data.
// RULE9 - Reading status drops the interrupt request.
// RULE10 - After a block, clear data request; more blocks set busy and repeat.
// RULE11 - Identify sets busy, fills block, raises data request and interrupt.
// RULE12 - Reserved bits and words of identify read as zero.
// RULE13 - Words 0, 2, 20, 21, 22 read 045Ah, C837h, 0003h, 4000h, 0004h.
// RULE14 - Word 47 holds 80h upper byte and max multiple count, giving 8010h.
// RULE15 - Word 49 reads 0B00h: IORDY, IORDY disable, LBA, DMA support.
// RULE16 - Word 53 reads 0007h flagging words 88, 64-70, 54-58 valid.
// RULE17 - Word 59 bit 8 marks valid multiple setting, bits 7-0 its count.
// RULE18 - Word 51 reads 0200h; word 64 reads 0003h for PIO modes 3, 4.
// RULE19 - Words 65, 66, 68 read 0078h; word 67 reads 00F0h.
// RULE20 - Word 63 gives active DMA mode high, supported modes low.
// RULE21 - Word 75 reads 0000h, queue depth in bits 4-0.
// RULE22 - Identify words delivered from word 0, one per data read.
module ata_pio_in_command_accept #(
    parameter int PREP_CYCLES = 4,
    parameter logic [7:0] MAX_MULTI = 8'h10,
    parameter logic [15:0] LOG_CYLS = 16'h0400,
    parameter logic [15:0] LOG_HEADS = 16'h0010,
    parameter logic [15:0] LOG_SPT = 16'h003f,
    parameter logic [31:0] LBA_TOTAL = 32'h000f_c000,
    parameter logic [7:0] DMA_ACTIVE = 8'h00,
    parameter logic [7:0] DMA_SUPPORTED = 8'h07
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic intrq,
    output logic [7:0] cmd_code,
    output logic cmd_start,
    output logic [27:0] lba,
    output logic blk_req,
    input wire logic blk_ready,
    output logic [7:0] buf_addr,
    input wire logic [15:0] buf_rdata,
    output logic buf_wvalid,
    output logic [15:0] buf_wdata
);
    import ata_pio_pkg::*;

    localparam int PC_W = $clog2(PREP_CYCLES + 1);
    localparam logic [PC_W-1:0] PREP_LOAD = PC_W'(PREP_CYCLES);

    function automatic logic is_pio_in(input logic [7:0] c);
        is_pio_in = (c == 8'h20) || (c == 8'h21) || (c == 8'h22) ||
            (c == 8'h23) || (c == 8'hc4) || (c == 8'he4) || (c == CMD_IDENTIFY);
    endfunction

    function automatic logic is_pio_out(input logic [7:0] c);
        is_pio_out = (c == 8'h30) || (c == 8'h31) || (c == 8'h32) ||
            (c == 8'h33) || (c == 8'he8) || (c == 8'h50);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFS_DATA) || (a == OFS_FEATURE) ||
            (a == OFS_COUNT) || (a == OFS_SECTOR) || (a == OFS_CYL_LO) ||
            (a == OFS_CYL_HI) || (a == OFS_DEV_HEAD) ||
            (a == OFS_STAT_CMD) || (a == OFS_ALT_STAT);
    endfunction

    function automatic logic [15:0] ident_word(input logic [7:0] w,
            input logic mult_ok, input logic [7:0] mult);
        ident_word = 16'h0000; // RULE12
        case (w)
            8'd0: ident_word = ID_W0; // RULE13
            8'd1, 8'd54: ident_word = LOG_CYLS;
            8'd2: ident_word = ID_W2; // RULE13
            8'd3, 8'd55: ident_word = LOG_HEADS;
            8'd6, 8'd56: ident_word = LOG_SPT;
            8'd20: ident_word = ID_W20; // RULE13
            8'd21: ident_word = ID_W21; // RULE13
            8'd22: ident_word = ID_W22; // RULE13
            8'd47: ident_word = {ID_W47_HI, MAX_MULTI}; // RULE14
            8'd49: ident_word = ID_W49; // RULE15
            8'd50: ident_word = ID_W50;
            8'd51: ident_word = ID_W51; // RULE18
            8'd53: ident_word = ID_W53; // RULE16
            8'd57, 8'd60: ident_word = LBA_TOTAL[15:0];
            8'd58, 8'd61: ident_word = LBA_TOTAL[31:16];
            8'd59: ident_word = {7'h00, mult_ok, mult}; // RULE17
            8'd63: ident_word = {DMA_ACTIVE, DMA_SUPPORTED}; // RULE20
            8'd64: ident_word = ID_W64; // RULE18
            8'd65, 8'd66, 8'd68: ident_word = ID_DMA_CYC; // RULE19
            8'd67: ident_word = ID_W67; // RULE19
            8'd75: ident_word = ID_W75; // RULE21
            default: begin
                if (w >= 8'd10 && w <= 8'd46 && w != 8'd20 &&
                        w != 8'd21 && w != 8'd22) begin
                    ident_word = ID_ASCII_PAD;
                end
            end
        endcase
    endfunction

    state_t state_q;
    logic bsy_q, drq_q, err_q, ident_q, mult_ok_q;
    logic [7:0] feature_q, count_q, sector_q, cyl_lo_q, cyl_hi_q, dh_q;
    logic [7:0] mult_q, error_q;
    logic [8:0] blocks_q;
    logic [PC_W-1:0] prep_q;
    logic aw_held_q, w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_hs, w_hs, ar_hs, do_wr, aw_held_d, w_held_d, bvalid_d, rvalid_d;
    logic wr_lo, cmd_wr, data_rd, data_wr, stat_rd;
    logic [7:0] status;

    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_lo = do_wr && wstrb_q[0];
    assign cmd_wr = wr_lo && awaddr_q == OFS_STAT_CMD && !bsy_q; // RULE1
    assign data_wr = do_wr && awaddr_q == OFS_DATA && state_q == S_DRQ_OUT;
    assign data_rd = ar_hs && s_axi_araddr == OFS_DATA && drq_q &&
        (state_q == S_DRQ_IN || state_q == S_INTR);
    assign stat_rd = ar_hs && s_axi_araddr == OFS_STAT_CMD;
    assign status = {bsy_q, 1'b1, 1'b0, 1'b1, drq_q, 2'b00, err_q};

    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        bvalid_d = s_axi_bvalid;
        rvalid_d = s_axi_rvalid;
        if (aw_hs) begin
            aw_held_d = 1'b1;
        end
        if (w_hs) begin
            w_held_d = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (ar_hs) begin
            rvalid_d = 1'b1;
        end
    end

    // Write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            s_axi_awready <= !aw_held_d;
            s_axi_wready <= !w_held_d;
            s_axi_bvalid <= bvalid_d;
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bresp <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_rvalid <= rvalid_d;
            s_axi_arready <= !rvalid_d;
            if (ar_hs) begin
                s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY :
                    RESP_DECERR;
                case (s_axi_araddr)
                    OFS_DATA: s_axi_rdata <= !data_rd ? 32'h0000_0000 :
                        {16'h0000, ident_q ?
                        ident_word(buf_addr, mult_ok_q, mult_q) :
                        buf_rdata}; // RULE22
                    OFS_FEATURE: s_axi_rdata <= {24'h000000, error_q};
                    OFS_COUNT: s_axi_rdata <= {24'h000000, count_q};
                    OFS_SECTOR: s_axi_rdata <= {24'h000000, sector_q};
                    OFS_CYL_LO: s_axi_rdata <= {24'h000000, cyl_lo_q};
                    OFS_CYL_HI: s_axi_rdata <= {24'h000000, cyl_hi_q};
                    OFS_DEV_HEAD: s_axi_rdata <= {24'h000000, dh_q};
                    OFS_STAT_CMD, OFS_ALT_STAT:
                        s_axi_rdata <= {24'h000000, status};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Task-file parameter registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            feature_q <= 8'h00;
            count_q <= 8'h01;
            sector_q <= 8'h01;
            cyl_lo_q <= 8'h00;
            cyl_hi_q <= 8'h00;
            dh_q <= 8'h00;
        end else if (wr_lo && !bsy_q) begin
            case (awaddr_q)
                OFS_FEATURE: feature_q <= wdata_q[7:0];
                OFS_COUNT: count_q <= wdata_q[7:0];
                OFS_SECTOR: sector_q <= wdata_q[7:0];
                OFS_CYL_LO: cyl_lo_q <= wdata_q[7:0];
                OFS_CYL_HI: cyl_hi_q <= wdata_q[7:0];
                OFS_DEV_HEAD: dh_q <= wdata_q[7:0];
                default: begin
                end
            endcase
        end
    end

    // Interrupt request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            intrq <= 1'b0;
        end else if (state_q == S_INTR && !intrq && !data_rd) begin
            intrq <= 1'b1; // RULE7
        end else if (stat_rd || cmd_wr) begin
            intrq <= 1'b0; // RULE9
        end
    end

    // Command sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_IDLE;
            bsy_q <= 1'b0;
            drq_q <= 1'b0;
            err_q <= 1'b0;
            error_q <= 8'h00;
            ident_q <= 1'b0;
            mult_q <= 8'h00;
            mult_ok_q <= 1'b0;
            blocks_q <= 9'h000;
            prep_q <= '0;
            cmd_code <= 8'h00;
            cmd_start <= 1'b0;
            lba <= 28'h0000000;
            blk_req <= 1'b0;
            buf_addr <= 8'h00;
            buf_wvalid <= 1'b0;
            buf_wdata <= 16'h0000;
        end else begin
            cmd_start <= 1'b0;
            buf_wvalid <= 1'b0;
            if (cmd_wr) begin
                bsy_q <= 1'b1; // RULE2
                drq_q <= 1'b0;
                err_q <= 1'b0;
                error_q <= 8'h00;
                cmd_code <= wdata_q[7:0];
                cmd_start <= 1'b1;
                lba <= {dh_q[3:0], cyl_hi_q, cyl_lo_q, sector_q}; // RULE6
                blocks_q <= (count_q == 8'h00) ? 9'h100 : {1'b0, count_q};
                ident_q <= wdata_q[7:0] == CMD_IDENTIFY; // RULE11
                buf_addr <= 8'h00;
                prep_q <= PREP_LOAD;
                if (is_pio_in(wdata_q[7:0])) begin
                    state_q <= S_PREP_IN; // RULE5
                    blk_req <= wdata_q[7:0] != CMD_IDENTIFY;
                end else if (is_pio_out(wdata_q[7:0])) begin
                    state_q <= S_PREP_OUT; // RULE3
                end else begin
                    state_q <= S_ND_BUSY;
                end
            end else begin
                case (state_q)
                    S_IDLE: begin
                    end
                    S_PREP_IN: begin
                        if (ident_q || blk_ready) begin
                            blk_req <= 1'b0;
                            drq_q <= 1'b1; // RULE7
                            bsy_q <= 1'b0; // RULE7
                            buf_addr <= 8'h00; // RULE22
                            state_q <= S_INTR;
                        end
                    end
                    S_INTR, S_DRQ_IN: begin
                        if (state_q == S_INTR && !intrq) begin
                            state_q <= S_DRQ_IN;
                        end
                        if (data_rd) begin
                            buf_addr <= buf_addr + 8'h01; // RULE22
                            if (buf_addr == LAST_WORD) begin
                                drq_q <= 1'b0; // RULE10
                                if (blocks_q > 9'h001 && !ident_q) begin
                                    blocks_q <= blocks_q - 9'h001;
                                    bsy_q <= 1'b1; // RULE10
                                    blk_req <= 1'b1;
                                    state_q <= S_PREP_IN;
                                end else begin
                                    state_q <= S_IDLE;
                                end
                            end
                        end
                    end
                    S_PREP_OUT: begin
                        if (prep_q != '0) begin
                            prep_q <= prep_q - PC_W'(1);
                        end else begin
                            drq_q <= 1'b1; // RULE3
                            bsy_q <= 1'b0; // RULE3
                            buf_addr <= 8'h00;
                            state_q <= S_DRQ_OUT;
                        end
                    end
                    S_DRQ_OUT: begin
                        if (data_wr) begin
                            buf_wvalid <= 1'b1;
                            buf_wdata <= wdata_q[15:0];
                            buf_addr <= buf_addr + 8'h01;
                            if (buf_addr == LAST_WORD) begin
                                drq_q <= 1'b0;
                                if (blocks_q > 9'h001) begin
                                    blocks_q <= blocks_q - 9'h001;
                                    bsy_q <= 1'b1;
                                    prep_q <= PREP_LOAD;
                                    state_q <= S_PREP_OUT;
                                end else begin
                                    state_q <= S_IDLE;
                                end
                            end
                        end
                    end
                    S_ND_BUSY: begin
                        if (prep_q != '0) begin
                            prep_q <= prep_q - PC_W'(1);
                        end else begin
                            bsy_q <= 1'b0;
                            state_q <= S_IDLE;
                            if (cmd_code == CMD_SET_MULT) begin
                                if (count_q <= MAX_MULTI) begin
                                    mult_q <= count_q;
                                    mult_ok_q <= count_q != 8'h00;
                                end else begin
                                    err_q <= 1'b1;
                                    error_q[ERR_ABRT] <= 1'b1;
                                end
                            end
                        end
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end
endmodule

// *** ata_pio_pkg.sv ***
package ata_pio_pkg;
    // Clock and busy timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int BUSY_MAX_NS = 400;
    localparam int BUSY_MAX_CYC = (BUSY_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
        BUSY_MAX_NS / CLK_PERIOD_NS;
    // Block geometry
    localparam int BLOCK_BYTES = 512;
    localparam int WORDS_PER_BLOCK = BLOCK_BYTES / 2;
    localparam logic [7:0] LAST_WORD = 8'(WORDS_PER_BLOCK - 1);
    // Register byte offsets
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_FEATURE = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_SECTOR = 8'h0c;
    localparam logic [7:0] OFS_CYL_LO = 8'h10;
    localparam logic [7:0] OFS_CYL_HI = 8'h14;
    localparam logic [7:0] OFS_DEV_HEAD = 8'h18;
    localparam logic [7:0] OFS_STAT_CMD = 8'h1c;
    localparam logic [7:0] OFS_ALT_STAT = 8'h20;
    // Status and error register bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ERR_ABRT = 2;
    // Command codes
    localparam logic [7:0] CMD_IDENTIFY = 8'hec;
    localparam logic [7:0] CMD_SET_MULT = 8'hc6;
    // Identify fixed words
    localparam logic [15:0] ID_W0 = 16'h045a;
    localparam logic [15:0] ID_W2 = 16'hc837;
    localparam logic [15:0] ID_W20 = 16'h0003;
    localparam logic [15:0] ID_W21 = 16'h4000;
    localparam logic [15:0] ID_W22 = 16'h0004;
    localparam logic [7:0] ID_W47_HI = 8'h80;
    localparam logic [15:0] ID_W49 = 16'h0b00;
    localparam logic [15:0] ID_W50 = 16'h4000;
    localparam logic [15:0] ID_W51 = 16'h0200;
    localparam logic [15:0] ID_W53 = 16'h0007;
    localparam logic [15:0] ID_W64 = 16'h0003;
    localparam logic [15:0] ID_DMA_CYC = 16'h0078;
    localparam logic [15:0] ID_W67 = 16'h00f0;
    localparam logic [15:0] ID_W75 = 16'h0000;
    localparam logic [15:0] ID_ASCII_PAD = 16'h2020;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [2:0] {
        S_IDLE, S_PREP_IN, S_DRQ_IN, S_INTR, S_PREP_OUT, S_DRQ_OUT, S_ND_BUSY
    } state_t;
endpackage

// *** ata_pio_chk_sva.sv ***
`timescale 1ns/1ps
module ata_pio_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic intrq,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_start,
    input wire logic blk_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_rd_answer;
        s_ar_taken |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read answer late");
    property p_wr_answer;
        s_wr_both |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_decerr;
        s_axi_arvalid && s_axi_arready &&
            (s_axi_araddr > 8'h20 || s_axi_araddr[1:0] != 2'b00)
            |=> s_axi_rresp == 2'b11 && s_axi_rdata == 32'h0;
    endproperty
    a_decerr: assert property (p_decerr)
        else $error("unmapped read not refused");
    property p_intrq_clear;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h1c && intrq
            |=> !intrq;
    endproperty
    a_intrq_clear: assert property (p_intrq_clear)
        else $error("status read kept interrupt");
    property p_start_pulse;
        cmd_start |=> !cmd_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse too long");
    property p_id_intr;
        cmd_start && cmd_code == 8'hec |-> ##[1:20] intrq;
    endproperty
    a_id_intr: assert property (p_id_intr)
        else $error("identify interrupt late");
    property p_rd_req;
        cmd_start && cmd_code == 8'h20 |-> ##[0:1] blk_req;
    endproperty
    a_rd_req: assert property (p_rd_req)
        else $error("block fill not requested");
endmodule
bind ata_pio_in_command_accept ata_pio_chk u_chk (.*);

// *** ata_pio_drive_model.sv ***
`timescale 1ns/1ps
module ata_pio_drive_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic blk_req,
    output logic blk_ready,
    input wire logic [7:0] buf_addr,
    output logic [15:0] buf_rdata,
    input wire logic buf_wvalid,
    input wire logic [7:0] lat,
    output logic [15:0] wr_cnt
);
    logic [7:0] wait_q;
    logic [7:0] blk_q;
    logic req_q;
    // Fill delay, prompt or slow
    always_ff @(posedge aclk) begin
        if (!aresetn || !blk_req) begin
            wait_q <= 8'h00;
        end else if (wait_q != lat) begin
            wait_q <= wait_q + 8'h01;
        end
    end
    // Block numbering and written-word count
    always_ff @(posedge aclk) begin
        req_q <= blk_req && aresetn;
        if (!aresetn) begin
            blk_q <= 8'h00;
            wr_cnt <= 16'h0000;
        end else begin
            if (blk_req && !req_q) begin
                blk_q <= blk_q + 8'h01;
            end
            if (buf_wvalid) begin
                wr_cnt <= wr_cnt + 16'h0001;
            end
        end
    end
    assign blk_ready = blk_req && (wait_q == lat);
    // Block number high, word index low
    assign buf_rdata = {blk_q, buf_addr};
endmodule

// *** ata_pio_in_command_accept_tb.sv ***
`timescale 1ns/1ps
module ata_pio_in_command_accept_tb;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, intrq, cmd_start, blk_req, blk_ready, buf_wvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] cmd_code, buf_addr;
    logic [27:0] lba;
    logic [15:0] buf_rdata, buf_wdata, wr_cnt;
    logic [16:0] e;
    int mismatches = 0, num_checks = 0;
    ata_pio_in_command_accept u_ata_pio_in_command_accept (.*);
    ata_pio_drive_model u_ata_pio_drive_model (.*);
    initial begin
        forever #10 aclk = ~aclk;
    end
    task automatic close_out;
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, g);
        num_checks++;
        if (g !== x) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_ok, w_ok, b_ok;
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(negedge aclk);
            if (!(s_axi_awvalid || s_axi_wvalid || s_axi_bready)) break;
            aw_ok = s_axi_awready;
            w_ok = s_axi_wready;
            b_ok = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
            if (b_ok) s_axi_bready <= 1'b0;
        end
        if (i == 100) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic a_ok, r_ok;
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(negedge aclk);
            if (!(s_axi_arvalid || s_axi_rready)) break;
            a_ok = s_axi_arready;
            r_ok = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (a_ok) s_axi_arvalid <= 1'b0;
            if (r_ok) s_axi_rready <= 1'b0;
        end
        if (i == 100) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic wait_intrq;
        int i;
        for (i = 0; i < 2000 && intrq !== 1'b1; i++) @(negedge aclk);
        if (i == 2000) begin
            mismatches++;
            close_out();
        end
    endtask
    // Identify word: care bit, then value
    function automatic logic [16:0] id_exp(input int w);
        if ((w >= 10 && w <= 19) || (w >= 23 && w <= 46)) return 17'h12020;
        case (w)
            0: return 17'h1045a;
            2: return 17'h1c837;
            20: return 17'h10003;
            21: return 17'h14000;
            22: return 17'h10004;
            47: return 17'h18010;
            49: return 17'h10b00;
            50: return 17'h14000;
            51: return 17'h10200;
            53: return 17'h10007;
            59: return 17'h10108;
            63: return 17'h10007;
            64: return 17'h10003;
            65, 66, 68: return 17'h10078;
            67: return 17'h100f0;
            4, 5, 48, 52, 62, 75: return 17'h10000;
            default: return {w >= 69, 16'h0000};
        endcase
    endfunction
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h1c);
        chk("status", 32'h50, d);
        rd(8'h40);
        chk("bad rresp", 32'h3, {30'h0, r});
        wr(8'h41, 32'h0);
        chk("bad bresp", 32'h3, {30'h0, r});
        wr(8'h08, 32'h8);
        wr(8'h1c, 32'hc6);
        repeat (10) @(posedge aclk);
        wr(8'h1c, 32'hec);
        wait_intrq();
        rd(8'h20);
        chk("id alt", 32'h58, d);
        rd(8'h1c);
        chk("id intrq", 32'h0, {31'h0, intrq});
        for (int w = 0; w < 256; w++) begin
            rd(8'h00);
            e = id_exp(w);
            if (e[16]) chk("id word", {16'h0, e[15:0]}, d);
        end
        rd(8'h1c);
        chk("id end", 32'h50, d);
        lat <= 8'h28;
        wr(8'h08, 32'h2);
        wr(8'h0c, 32'h11);
        wr(8'h10, 32'h22);
        wr(8'h14, 32'h33);
        wr(8'h18, 32'he4);
        wr(8'h1c, 32'h20);
        rd(8'h20);
        chk("rd busy", 32'h80, d & 32'h88);
        wr(8'h1c, 32'hec);
        chk("refused", 32'h20, {24'h0, cmd_code});
        chk("lba", 32'h4332211, {4'h0, lba});
        for (int b = 0; b < 2; b++) begin
            wait_intrq();
            rd(8'h1c);
            chk("blk stat", 32'h58, d);
            for (int w = 0; w < 256; w++) begin
                rd(8'h00);
                chk("blk word", {16'h0, 8'(b + 1), 8'(w)}, d);
            end
            rd(8'h20);
            chk("blk next", (b == 0) ? 32'h80 : 32'h0, d & 32'h88);
        end
        lat <= 8'h00;
        wr(8'h08, 32'h1);
        wr(8'h1c, 32'h30);
        repeat (20) @(posedge aclk);
        rd(8'h20);
        chk("wr drq", 32'h08, d & 32'h88);
        for (int w = 0; w < 256; w++) wr(8'h00, 32'(w));
        chk("wr words", 32'h100, {16'h0, wr_cnt});
        chk("wr last", 32'hff, {16'h0, buf_wdata});
        repeat (20) @(posedge aclk);
        rd(8'h1c);
        chk("wr end", 32'h50, d);
        close_out();
    end
endmodule
